// *** hw/fhc_bus_cycle.sv ***
// module: one asynchronous flash bus cycle, read or write, with pin timing
`timescale 1ns/1ps
module fhc_bus_cycle
	import fhc_pkg::*;
(
	input  wire logic              clk,
	input  wire logic              rst,
	input  wire logic              start,
	input  wire logic              wr,
	input  wire logic [ADDR_W-1:0] addr,
	input  wire logic [DATA_W-1:0] wdata,
	output logic                   done,
	output logic      [DATA_W-1:0] rdata,
	output logic                   ce_n,
	output logic                   oe_n,
	output logic                   we_n,
	output logic      [ADDR_W-1:0] a,
	output logic      [DATA_W-1:0] dq_o,
	output logic                   dq_oe,
	input  wire logic [DATA_W-1:0] dq_i
);
	localparam fhc_bus_s BUS_RST = '{ph: P_IDLE, ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1, default: '0};

	fhc_bus_s r;
	fhc_bus_s n;

	// cycle phases: enable, strobe, hold, then a gap with every strobe high
	always_comb
	begin
		n = r;
		n.done = 1'b0;
		n.s1 = dq_i;
		n.s2 = r.s1;
		case (r.ph)
			P_IDLE:
				if (start)
				begin
					n.ph = P_SETUP;
					n.wr = wr;
					n.a = addr;
					n.wd = wdata;
					n.ce_n = 1'b0;
					n.dq_oe = wr;
				end
			P_SETUP:
			begin
				n.ph = P_STROBE;
				n.we_n = !r.wr;
				n.oe_n = r.wr;
				// reads wait two extra cycles for the pin synchroniser
				n.cnt = r.wr ? 4'(T_WLWH_CYC - 1) : 4'(T_ACC_CYC + 1);
			end
			P_STROBE:
				if (r.cnt == 4'h0)
				begin
					n.ph = P_HOLD;
					n.we_n = 1'b1;
					n.oe_n = 1'b1;
					if (!r.wr)
						n.rd = r.s2;
				end
				else
					n.cnt = r.cnt - 4'h1;
			P_HOLD:
			begin
				n.ph = P_GAP;
				n.ce_n = 1'b1;
				n.dq_oe = 1'b0;
				n.cnt = 4'(T_GAP_CYC - 1);
			end
			P_GAP:
				if (r.cnt == 4'h0)
				begin
					n.ph = P_IDLE;
					n.done = 1'b1;
				end
				else
					n.cnt = r.cnt - 4'h1;
			default: n.ph = P_IDLE;
		endcase
	end

	always_ff @(posedge clk)
	begin
		if (rst)
			r <= BUS_RST;
		else
			r <= n;
	end

	assign done  = r.done;
	assign rdata = r.rd;
	assign ce_n  = r.ce_n;
	assign oe_n  = r.oe_n;
	assign we_n  = r.we_n;
	assign a     = r.a;
	assign dq_o  = r.wd;
	assign dq_oe = r.dq_oe;

	// every read ends with output enable high for a full gap, so status refreshes
	property p_oe_toggle;
		@(posedge clk) disable iff (rst)
		$rose(r.oe_n) |-> r.oe_n [*3] ##1 r.ph == P_IDLE;
	endproperty
	a_oe_toggle: assert property (p_oe_toggle) else $error("output enable not held high between reads");

	property p_we_width;
		@(posedge clk) disable iff (rst)
		$fell(r.we_n) |-> !r.we_n [*3] ##1 r.we_n;
	endproperty
	a_we_width: assert property (p_we_width) else $error("write strobe width wrong");
endmodule // fhc_bus_cycle

// *** hw/fhc_host.sv ***
// module: APB-controlled host sequencer for a boot-block parallel flash
// Contract
// - after programming the last word, write the read-array code.
// - clear the supply-low flag before any further program or erase.
// - erase is setup code then confirm code, both inside the target block.
// - toggle output enable between status reads; device refreshes status then.
// - after the last block erase, write the read-array code.
// - after suspend, poll until ready and suspended before going on.
// - while suspended, write read-array and read only other blocks.
// - full status check after each word or once after many.
// - resume code continues a suspended erase; suspend state clears.
`timescale 1ns/1ps
module fhc_host
	import fhc_pkg::*;
#(
	parameter logic [15:0] CMD_READ_STATUS  = 16'h0070,
	parameter logic [15:0] CMD_CLEAR_STATUS = 16'h0050
)(
	input  wire logic              MCLK,
	input  wire logic              SYS_RST,
	input  wire logic              PSEL,
	input  wire logic              PENABLE,
	input  wire logic              PWRITE,
	input  wire logic [7:0]        PADDR,
	input  wire logic [31:0]       PWDATA,
	output logic      [31:0]       PRDATA,
	output logic                   PREADY,
	output logic                   PSLVERR,
	output logic                   IRQ,
	output logic                   FL_CE_N,
	output logic                   FL_OE_N,
	output logic                   FL_WE_N,
	output logic      [ADDR_W-1:0] FL_ADDR,
	input  wire logic [DATA_W-1:0] FL_DQ_I,
	output logic      [DATA_W-1:0] FL_DQ_O,
	output logic                   FL_DQ_OE,
	output logic                   FL_RP_N,
	output logic                   FL_BOOT_UNLOCK
);
	localparam fhc_main_s MAIN_RST = '{st: S_RESET, op: OP_READ, ctrl: CTRL_RST, array_mode: 1'b1,
		wait_cnt: 4'(T_RPHW_CYC), default: '0};

	fhc_main_s          r;
	fhc_main_s          n;
	logic               bc_done;
	logic [DATA_W-1:0]  bc_rdata;
	logic [IRQ_W-1:0]   ev;
	logic [IRQ_W-1:0]   clr;
	logic               wr_acc;
	logic               rd_setup;
	logic               launch;
	logic               refuse;
	fhc_op_e            op_in;
	// every property below samples on the system clock and sleeps through reset
	default clocking dflt_cb @(posedge MCLK);
	endclocking
	default disable iff (SYS_RST);

	// decoded register offsets
	function automatic logic mapped(input logic [7:0] a);
		mapped = (a[1:0] == 2'b00) && (a <= REG_IRQ_MASK);
	endfunction

	// blocks never straddle a region, so a region match is a safe same-block test
	function automatic logic same_blk(input logic [ADDR_W-1:0] x, input logic [ADDR_W-1:0] y);
		same_blk = x[ADDR_W-1:BLK_LSB] == y[ADDR_W-1:BLK_LSB];
	endfunction

	// start one bus cycle and move to the state that waits for it
	function automatic fhc_main_s issue(input fhc_main_s s, input logic w, input logic [ADDR_W-1:0] ad,
		input logic [DATA_W-1:0] d, input fhc_state_e nx);
		issue = s;
		issue.bc_start = 1'b1;
		issue.bc_wr = w;
		issue.bc_addr = ad;
		issue.bc_wd = d;
		issue.st = nx;
	endfunction

	fhc_bus_cycle u_bus (.clk(MCLK), .rst(SYS_RST), .start(r.bc_start), .wr(r.bc_wr), .addr(r.bc_addr),
		.wdata(r.bc_wd), .done(bc_done), .rdata(bc_rdata), .ce_n(FL_CE_N), .oe_n(FL_OE_N), .we_n(FL_WE_N),
		.a(FL_ADDR), .dq_o(FL_DQ_O), .dq_oe(FL_DQ_OE), .dq_i(FL_DQ_I));

	// host-side refusals keep the device out of sequences it would reject or corrupt
	always_comb
	begin
		op_in = fhc_op_e'(PWDATA[2:0]);
		case (op_in)
			OP_PROG, OP_ERASE: refuse = r.vpp_low || r.susp || r.erase_act;
			OP_SUSP:           refuse = !r.erase_act || r.susp;
			OP_RESUME:         refuse = !r.susp;
			OP_CLEAR:          refuse = r.erase_act;  // device ignores clear while an erase is open
			OP_WAIT:           refuse = !r.erase_act || r.susp;
			OP_READ:           refuse = r.susp ? same_blk(r.addr, r.erase_addr) : r.erase_act;
			default:           refuse = 1'b0;
		endcase
	end

	// register bus, sequencer and interrupt status, all in one next-state process
	always_comb
	begin
		n = r;
		n.bc_start = 1'b0;
		ev = '0;
		wr_acc = PSEL && PENABLE && PWRITE;
		rd_setup = PSEL && !PENABLE && !PWRITE;
		launch = wr_acc && (PADDR == REG_CMD);
		clr = (wr_acc && PADDR == REG_IRQ_STAT) ? PWDATA[IRQ_W-1:0] : '0;
		if (wr_acc)
			case (PADDR)
				REG_CTRL:     n.ctrl = PWDATA[CTRL_W-1:0];
				REG_ADDR:     n.addr = PWDATA[ADDR_W-1:0];
				REG_WDATA:    n.wdata = PWDATA[DATA_W-1:0];
				REG_IRQ_MASK: n.irq_mask = PWDATA[IRQ_W-1:0];
				default:      ;
			endcase
		if (launch && (r.st != S_IDLE || r.ctrl[CTL_RP_ASSERT]))
			ev[IRQ_REFUSED] = 1'b1;
		case (r.st)
			S_RESET:
			begin
				// device comes out of reset idle, in array mode, with status cleared
				n.erase_act = 1'b0;
				n.susp = 1'b0;
				n.vpp_low = 1'b0;
				n.array_mode = 1'b1;
				n.status_mode = 1'b0;
				if (r.ctrl[CTL_RP_ASSERT])
					n.wait_cnt = 4'(T_RPHW_CYC);
				else if (r.wait_cnt == 4'h0)
					n.st = S_IDLE;
				else
					n.wait_cnt = r.wait_cnt - 4'h1;
			end
			S_IDLE:
				if (r.ctrl[CTL_RP_ASSERT])
					n.st = S_RESET;
				else if (launch && refuse)
					ev[IRQ_REFUSED] = 1'b1;
				else if (launch)
				begin
					n.op = op_in;
					case (op_in)
						OP_READ:
							if (r.array_mode)
								n = issue(n, 1'b0, r.addr, '0, S_READ);
							else
								n = issue(n, 1'b1, r.addr, CMD_READ_ARRAY, S_WR1);
						OP_PROG:   n = issue(n, 1'b1, r.addr, CMD_PROG_SETUP, S_WR1);
						OP_ERASE:
						begin
							n.erase_addr = r.addr;
							n = issue(n, 1'b1, r.addr, CMD_ERASE_SETUP, S_WR1);
						end
						OP_SUSP:   n = issue(n, 1'b1, r.erase_addr, CMD_SUSPEND, S_WR1);
						OP_RESUME: n = issue(n, 1'b1, r.erase_addr, CMD_RESUME, S_WR1);
						OP_WAIT:
							if (r.status_mode)
								n = issue(n, 1'b0, r.erase_addr, '0, S_POLL);
							else
								n = issue(n, 1'b1, r.erase_addr, CMD_READ_STATUS, S_WR1);
						OP_CLEAR:  n = issue(n, 1'b1, r.addr, CMD_CLEAR_STATUS, S_WR1);
						default:   n = issue(n, 1'b1, r.addr, CMD_READ_STATUS, S_WR1);
					endcase
				end
			S_WR1:
				if (bc_done)
				begin
					n.array_mode = 1'b0;
					n.status_mode = 1'b1;
					case (r.op)
						OP_READ:
						begin
							n.array_mode = 1'b1;
							n.status_mode = 1'b0;
							n = issue(n, 1'b0, r.addr, '0, S_READ);
						end
						OP_PROG:   n = issue(n, 1'b1, r.addr, r.wdata, S_WR2);
						OP_ERASE:  n = issue(n, 1'b1, r.erase_addr, CMD_CONFIRM, S_WR2);
						OP_SUSP:   n = issue(n, 1'b0, r.erase_addr, '0, S_POLL);
						OP_RESUME:
						begin
							n.susp = 1'b0;
							n.st = S_FIN;
						end
						OP_WAIT:   n = issue(n, 1'b0, r.erase_addr, '0, S_POLL);
						OP_STATUS: n = issue(n, 1'b0, r.addr, '0, S_READ);
						default:
						begin
							n.vpp_low = 1'b0;
							n.array_mode = r.array_mode;  // clear-status leaves the read mode alone
							n.status_mode = r.status_mode;
							n.st = S_FIN;
						end
					endcase
				end
			S_WR2:
				if (bc_done)
				begin
					if (r.op == OP_ERASE)
						n.erase_act = 1'b1;
					if (r.op == OP_ERASE && r.ctrl[CTL_NOWAIT])
						n.st = S_FIN;
					else
						n = issue(n, 1'b0, r.bc_addr, '0, S_POLL);
				end
			S_POLL:
				if (bc_done)
				begin
					n.fstat = bc_rdata[7:0];
					// each poll is its own read cycle, so output enable toggles between them
					if (!bc_rdata[SB_READY])
						n = issue(n, 1'b0, r.bc_addr, '0, S_POLL);
					else if (r.op == OP_SUSP && bc_rdata[SB_SUSP])
					begin
						n.susp = 1'b1;
						n.st = S_FIN;
					end
					else
					begin
						if (r.op != OP_PROG)
							n.erase_act = 1'b0;
						if (bc_rdata[SB_VPP])
							n.vpp_low = 1'b1;
						// deferred checking: program failures are left for one later status read
						if (r.op != OP_PROG || r.ctrl[CTL_CHECK_EACH])
						begin
							ev[IRQ_VPP] = bc_rdata[SB_VPP];
							ev[IRQ_SEQ] = bc_rdata[SB_PROG] && bc_rdata[SB_ERASE];
							ev[IRQ_EFAIL] = bc_rdata[SB_ERASE] && !bc_rdata[SB_PROG];
							ev[IRQ_PFAIL] = bc_rdata[SB_PROG] && !bc_rdata[SB_ERASE];
						end
						if (r.ctrl[CTL_AUTO_EXIT])
							n = issue(n, 1'b1, r.bc_addr, CMD_READ_ARRAY, S_EXIT);
						else
							n.st = S_FIN;
					end
				end
			S_EXIT:
				if (bc_done)
				begin
					n.array_mode = 1'b1;
					n.status_mode = 1'b0;
					n.st = S_FIN;
				end
			S_READ:
				if (bc_done)
				begin
					n.rdata = bc_rdata;
					if (r.op == OP_STATUS)
						n.fstat = bc_rdata[7:0];
					n.st = S_FIN;
				end
			S_FIN:
			begin
				ev[IRQ_DONE] = 1'b1;
				n.st = S_IDLE;
			end
			default: n.st = S_RESET;
		endcase
		// a new event wins over a clear in the same cycle
		n.irq_st = (r.irq_st & ~clr) | ev;
		if (rd_setup)
			case (PADDR)
				REG_CTRL:     n.prdata = {27'h0, r.ctrl};
				REG_ADDR:     n.prdata = {14'h0, r.addr};
				REG_WDATA:    n.prdata = {16'h0, r.wdata};
				REG_STATUS:   n.prdata = {16'h0, r.fstat, 4'h0, r.vpp_low, r.erase_act, r.susp, r.st != S_IDLE};
				REG_RDATA:    n.prdata = {16'h0, r.rdata};
				REG_IRQ_STAT: n.prdata = {26'h0, r.irq_st};
				REG_IRQ_MASK: n.prdata = {26'h0, r.irq_mask};
				default:      n.prdata = 32'h0;
			endcase
	end

	always_ff @(posedge MCLK)
	begin
		if (SYS_RST)
			r <= MAIN_RST;
		else
			r <= n;
	end

	// zero-wait slave; error only on unmapped offsets
	assign PREADY         = 1'b1;
	assign PSLVERR        = PSEL && PENABLE && !mapped(PADDR);
	assign PRDATA         = r.prdata;
	assign IRQ            = |(r.irq_st & r.irq_mask);
	assign FL_RP_N        = !r.ctrl[CTL_RP_ASSERT];
	assign FL_BOOT_UNLOCK = r.ctrl[CTL_UNLOCK];

	property p_prog_exit;
		(r.st == S_POLL && bc_done && bc_rdata[SB_READY] && r.op == OP_PROG && r.ctrl[CTL_AUTO_EXIT])
			|=> r.st == S_EXIT && r.bc_start && r.bc_wd == CMD_READ_ARRAY;
	endproperty
	a_prog_exit: assert property (p_prog_exit) else $error("no read-array after program");
	property p_erase_exit;
		(r.st == S_POLL && bc_done && bc_rdata[SB_READY] && r.op == OP_ERASE && r.ctrl[CTL_AUTO_EXIT])
			|=> ##[1:20] (r.st == S_EXIT && bc_done) ##1 r.array_mode;
	endproperty
	a_erase_exit: assert property (p_erase_exit) else $error("no read-array after erase");
	property p_vpp_block;
		(r.st == S_WR1 && r.bc_start && (r.op == OP_PROG || r.op == OP_ERASE)) |-> !$past(r.vpp_low);
	endproperty
	a_vpp_block: assert property (p_vpp_block) else $error("program or erase with supply-low set");
	property p_erase_pair;
		(r.st == S_WR2 && r.bc_start && r.op == OP_ERASE)
			|-> r.bc_wd == CMD_CONFIRM && r.bc_addr == r.erase_addr && $past(r.st, 2) != S_IDLE;
	endproperty
	a_erase_pair: assert property (p_erase_pair) else $error("erase confirm not paired with setup");
	property p_susp_done;
		$rose(r.susp) |-> r.fstat[SB_READY] && r.fstat[SB_SUSP] ##1 r.st == S_IDLE;
	endproperty
	a_susp_done: assert property (p_susp_done) else $error("suspend taken without ready and suspended");
	property p_susp_read;
		(r.bc_start && !r.bc_wr && r.st == S_READ && r.susp) |-> !same_blk(r.bc_addr, r.erase_addr);
	endproperty
	a_susp_read: assert property (p_susp_read) else $error("read of the block under erase");
	property p_deferred;
		(r.op == OP_PROG && !r.ctrl[CTL_CHECK_EACH]) |-> ev[IRQ_PFAIL] == 1'b0 && ev[IRQ_SEQ] == 1'b0;
	endproperty
	a_deferred: assert property (p_deferred) else $error("program failure checked while deferred");
	property p_resume;
		(r.st == S_WR1 && r.op == OP_RESUME && bc_done) |=> !r.susp ##1 r.st == S_IDLE;
	endproperty
	a_resume: assert property (p_resume) else $error("suspend state kept after resume");
endmodule // fhc_host

// *** hw/fhc_pkg.sv ***
// package: constants and types of the flash erase/program host controller
package fhc_pkg;
	// timing, figures in ns, counts derived at the 40 MHz system clock
	localparam int CLK_NS     = 25;
	localparam int T_WLWH_NS  = 60;   // write strobe low
	localparam int T_ACC_NS   = 90;   // access time from enable
	localparam int T_GAP_NS   = 35;   // output disable before the next cycle
	localparam int T_RPHW_NS  = 300;  // reset release to first access
	localparam int T_WLWH_CYC = (T_WLWH_NS + CLK_NS - 1) / CLK_NS;
	localparam int T_ACC_CYC  = (T_ACC_NS + CLK_NS - 1) / CLK_NS;
	localparam int T_GAP_CYC  = (T_GAP_NS + CLK_NS - 1) / CLK_NS;
	localparam int T_RPHW_CYC = (T_RPHW_NS + CLK_NS - 1) / CLK_NS;

	localparam int ADDR_W  = 18;
	localparam int DATA_W  = 16;
	localparam int BLK_LSB = 16;      // 64K-word region holds any whole block

	// device command codes
	localparam logic [15:0] CMD_READ_ARRAY  = 16'h00FF;
	localparam logic [15:0] CMD_PROG_SETUP  = 16'h0040;
	localparam logic [15:0] CMD_ERASE_SETUP = 16'h0020;
	localparam logic [15:0] CMD_CONFIRM     = 16'h00D0;
	localparam logic [15:0] CMD_SUSPEND     = 16'h00B0;
	localparam logic [15:0] CMD_RESUME      = 16'h00D0;

	// device status byte bit positions
	localparam int SB_VPP   = 3;
	localparam int SB_PROG  = 4;
	localparam int SB_ERASE = 5;
	localparam int SB_SUSP  = 6;
	localparam int SB_READY = 7;

	// register offsets
	localparam logic [7:0] REG_CTRL     = 8'h00;
	localparam logic [7:0] REG_CMD      = 8'h04;
	localparam logic [7:0] REG_ADDR     = 8'h08;
	localparam logic [7:0] REG_WDATA    = 8'h0C;
	localparam logic [7:0] REG_STATUS   = 8'h10;
	localparam logic [7:0] REG_RDATA    = 8'h14;
	localparam logic [7:0] REG_IRQ_STAT = 8'h18;
	localparam logic [7:0] REG_IRQ_MASK = 8'h1C;

	// control fields
	localparam int         CTRL_W         = 5;
	localparam int         CTL_RP_ASSERT  = 0;
	localparam int         CTL_UNLOCK     = 1;
	localparam int         CTL_CHECK_EACH = 2;
	localparam int         CTL_AUTO_EXIT  = 3;
	localparam int         CTL_NOWAIT     = 4;
	localparam logic [4:0] CTRL_RST       = 5'h0C;

	// status register fields
	localparam int ST_BUSY  = 0;
	localparam int ST_SUSP  = 1;
	localparam int ST_EACT  = 2;
	localparam int ST_VPP   = 3;
	localparam int ST_FSTAT = 8;

	// interrupt sources
	localparam int IRQ_W       = 6;
	localparam int IRQ_DONE    = 0;
	localparam int IRQ_VPP     = 1;
	localparam int IRQ_PFAIL   = 2;
	localparam int IRQ_EFAIL   = 3;
	localparam int IRQ_SEQ     = 4;
	localparam int IRQ_REFUSED = 5;

	typedef enum logic [2:0] {
		OP_READ = 3'b000, OP_PROG = 3'b001, OP_ERASE = 3'b010, OP_SUSP = 3'b011,
		OP_RESUME = 3'b100, OP_WAIT = 3'b101, OP_CLEAR = 3'b110, OP_STATUS = 3'b111
	} fhc_op_e;

	typedef enum logic [2:0] {
		S_RESET = 3'b000, S_IDLE = 3'b001, S_WR1 = 3'b010, S_WR2 = 3'b011,
		S_POLL = 3'b100, S_EXIT = 3'b101, S_READ = 3'b110, S_FIN = 3'b111
	} fhc_state_e;

	typedef enum logic [2:0] {
		P_IDLE = 3'b000, P_SETUP = 3'b001, P_STROBE = 3'b010, P_HOLD = 3'b011, P_GAP = 3'b100
	} fhc_phase_e;

	typedef struct packed {
		fhc_phase_e          ph;
		logic [3:0]          cnt;
		logic                wr;
		logic                ce_n;
		logic                oe_n;
		logic                we_n;
		logic                dq_oe;
		logic [ADDR_W-1:0]   a;
		logic [DATA_W-1:0]   wd;
		logic [DATA_W-1:0]   rd;
		logic [DATA_W-1:0]   s1;
		logic [DATA_W-1:0]   s2;
		logic                done;
	} fhc_bus_s;

	typedef struct packed {
		fhc_state_e          st;
		fhc_op_e             op;
		logic [CTRL_W-1:0]   ctrl;
		logic [IRQ_W-1:0]    irq_st;
		logic [IRQ_W-1:0]    irq_mask;
		logic [ADDR_W-1:0]   addr;
		logic [ADDR_W-1:0]   erase_addr;
		logic [DATA_W-1:0]   wdata;
		logic [DATA_W-1:0]   rdata;
		logic [7:0]          fstat;
		logic                array_mode;
		logic                status_mode;
		logic                erase_act;
		logic                susp;
		logic                vpp_low;
		logic [3:0]          wait_cnt;
		logic                bc_start;
		logic                bc_wr;
		logic [ADDR_W-1:0]   bc_addr;
		logic [DATA_W-1:0]   bc_wd;
		logic [31:0]         prdata;
	} fhc_main_s;
endpackage

// *** sim/fhc_flash_model.sv ***
// flash device model: command interpreter, status byte and a small word array
`timescale 1ns/1ps
module fhc_flash_model
	import fhc_pkg::*;
#(
	parameter int BUSY_RD = 3 // status reads until an operation shows ready; kept short for run time
)(
	input  wire logic              ce_n,
	input  wire logic              oe_n,
	input  wire logic              we_n,
	input  wire logic [ADDR_W-1:0] a,
	input  wire logic [DATA_W-1:0] dq_w,
	input  wire logic              rp_n,
	input  wire logic              unlock,
	input  wire logic              fail_p,
	input  wire logic              fail_e,
	input  wire logic              bad_seq,
	input  wire logic              vpp_low,
	output logic      [DATA_W-1:0] dq
);
	logic [DATA_W-1:0] mem [int];
	logic [5:3]        sr = 3'b000; // known at power-up: the reset pin need never pulse
	logic [7:0]        c;
	logic              boot;
	logic              susp_q = 1'b0;
	logic              erasing = 1'b0;
	logic [DATA_W-1:0] outv;
	logic [DATA_W-1:0] last;
	int                busy;
	int                md;

	function automatic logic [DATA_W-1:0] rdm(input int k);
		return mem.exists(k) ? mem[k] : 16'hFFFF;
	endfunction

	// a released bus shows the inverse of its last value, so a late sample cannot match
	assign dq = (!ce_n && !oe_n) ? outv : ~last;

	// reset pin low clears the sequencer and the status byte
	always @(negedge rp_n)
	begin
		sr = 3'b000;
		busy = 0;
		md = 0;
		susp_q = 0;
		erasing = 0;
	end

	// status is refreshed on every output-enable fall; busy drains per status read
	always @(negedge oe_n)
	begin
		if (!ce_n)
		begin
			if (busy > 0 && !susp_q)
				busy--;
			if (busy == 0)
				erasing = 0;
			outv = md == 0 ? rdm(int'(a)) : {8'h00, busy == 0 || susp_q, susp_q, sr, 3'b000};
			last = outv;
		end
	end

	// commands are latched on the rising write strobe
	always @(posedge we_n)
	begin
		if (!ce_n && rp_n)
		begin
			c = dq_w[7:0];
			boot = a[17:16] == 2'b11 && !unlock;
			if (busy > 0 && !susp_q)
			begin
				if (c == 8'hB0 && erasing)
					susp_q = 1;
			end
			else if (susp_q)
			begin
				if (c == 8'hFF)
					md = 0;
				else if (c == 8'h70)
					md = 1;
				else if (c == 8'hD0)
				begin
					susp_q = 0;
					md = 1;
				end
			end
			else if (md == 2)
			begin
				md = 1;
				busy = BUSY_RD;
				if (vpp_low)
					sr[3] = 1;
				else if (boot || fail_p)
					sr[4] = 1;
				else
					mem[int'(a)] = rdm(int'(a)) & dq_w;
			end
			else if (md == 3)
			begin
				md = 1;
				busy = BUSY_RD;
				erasing = 1;
				if (c != 8'hD0 || bad_seq)
					sr[5:4] = 2'b11;
				else if (vpp_low)
					sr[3] = 1;
				else if (boot || fail_e)
					sr[5] = 1;
				else
					foreach (mem[k])
						if (k[17:16] == a[17:16])
							mem[k] = 16'hFFFF;
			end
			else if (c == 8'hFF)
				md = 0;
			else if (c == 8'h70)
				md = 1;
			else if (c == 8'h50)
				sr = 3'b000;
			else if (c == 8'h40)
				md = 2;
			else if (c == 8'h20)
				md = 3;
		end
	end
endmodule // fhc_flash_model

// *** sim/tb_top.sv ***
// testbench: APB-driven flash host sequencer against the flash device model
`timescale 1ns/1ps
module tb_top
	import fhc_pkg::*;
;
	logic              mclk = 1'b0;
	logic              sys_rst;
	logic              psel;
	logic              penable;
	logic              pwrite;
	logic [7:0]        paddr;
	logic [31:0]       pwdata;
	logic [31:0]       prdata;
	logic              pready;
	logic              pslverr;
	logic              irq;
	logic              ce_n;
	logic              oe_n;
	logic              we_n;
	logic [ADDR_W-1:0] fa;
	logic [DATA_W-1:0] dqo;
	logic [DATA_W-1:0] dqi;
	logic [DATA_W-1:0] mdq;
	logic              dqoe;
	logic              rp_n;
	logic              unlock;
	logic              fail_p;
	logic              fail_e;
	logic              bad_seq;
	logic              vpp_low;
	logic              err;
	logic [5:0]        mask_v;
	logic [31:0]       v;
	int                error_cnt = 0;
	int                n_compared = 0;
	int                cyc = 0;

	always #12.5 mclk = ~mclk;

	// the data wire carries whichever party drives it
	assign dqi = dqoe ? dqo : mdq;

	fhc_host dut_u (.MCLK(mclk), .SYS_RST(sys_rst), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
		.PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr), .IRQ(irq),
		.FL_CE_N(ce_n), .FL_OE_N(oe_n), .FL_WE_N(we_n), .FL_ADDR(fa), .FL_DQ_I(dqi), .FL_DQ_O(dqo),
		.FL_DQ_OE(dqoe), .FL_RP_N(rp_n), .FL_BOOT_UNLOCK(unlock));

	fhc_flash_model flash_u (.ce_n(ce_n), .oe_n(oe_n), .we_n(we_n), .a(fa), .dq_w(dqo), .rp_n(rp_n),
		.unlock(unlock), .fail_p(fail_p), .fail_e(fail_e), .bad_seq(bad_seq), .vpp_low(vpp_low), .dq(mdq));

	task automatic wrap_up();
		$display("compared %0d, mismatches %0d", n_compared, error_cnt);
		if (error_cnt == 0 && n_compared > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	// a hang counts as a mismatch and goes to the closing report
	always @(posedge mclk)
	begin
		cyc++;
		if (cyc == 60000)
		begin
			error_cnt++;
			wrap_up();
		end
	end

	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		n_compared++;
		if (g !== e)
		begin
			error_cnt++;
			$display("wrong value at %0t: got %h expected %h", $time, g, e);
		end
	endtask

	// one APB transfer; data and error are taken at the edge that samples pready
	task automatic apb(input logic w, input logic [7:0] ad, input logic [31:0] wd, output logic [31:0] rd);
		@(posedge mclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= ad;
		pwdata <= wd;
		@(posedge mclk);
		penable <= 1'b1;
		do
			@(posedge mclk);
		while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic wr(input logic [7:0] ad, input logic [31:0] wd);
		logic [31:0] x;
		apb(1'b1, ad, wd, x);
	endtask

	task automatic rd(input logic [7:0] ad, output logic [31:0] x);
		apb(1'b0, ad, 32'h0, x);
	endtask

	task automatic aw(input logic [17:0] ad, input logic [15:0] d);
		wr(REG_ADDR, {14'h0, ad});
		wr(REG_WDATA, {16'h0, d});
	endtask

	// issue one operation, wait for done or refusal, check events and the interrupt line
	task automatic run(input logic [2:0] op, input logic [5:0] e);
		logic [31:0] x;
		int          n;
		wr(REG_CMD, {29'h0, op});
		x = 32'h0;
		n = 0;
		while ((x & 32'h21) == 32'h0 && n < 300)
		begin
			rd(REG_IRQ_STAT, x);
			n++;
		end
		rd(REG_IRQ_STAT, x);
		chk(x, {26'h0, e});
		chk({31'h0, irq}, {31'h0, |(e & mask_v)});
		wr(REG_IRQ_STAT, 32'h3F);
		rd(REG_IRQ_STAT, x);
		chk({31'h0, irq}, 32'h0);
	endtask

	initial
	begin
		{psel, penable, pwrite, paddr, pwdata} = '0;
		{fail_p, fail_e, bad_seq, vpp_low} = 4'h0;
		sys_rst = 1'b1;
		mask_v = 6'h04;
		repeat (4) @(posedge mclk);
		sys_rst <= 1'b0;
		repeat (14) @(posedge mclk);
		rd(REG_CTRL, v);
		chk(v, 32'h0C);
		rd(8'h20, v);
		chk({31'h0, err}, 32'h1);
		wr(REG_IRQ_MASK, {26'h0, mask_v});
		$display("test reset done");
		aw(18'h00100, 16'h1234);
		run(OP_PROG, 6'h01);
		run(OP_READ, 6'h01);
		rd(REG_RDATA, v);
		chk(v, 32'h1234);
		run(OP_STATUS, 6'h01);
		rd(REG_STATUS, v);
		chk(v & 32'hFF00, 32'h8000);
		fail_p = 1'b1;
		run(OP_PROG, 6'h05);
		fail_p = 1'b0;
		aw(18'h00101, 16'h00C3);
		run(OP_PROG, 6'h05);
		run(OP_READ, 6'h01);
		rd(REG_RDATA, v);
		chk(v, 32'h00C3);
		run(OP_CLEAR, 6'h01);
		wr(REG_CTRL, 32'h08);
		fail_p = 1'b1;
		run(OP_PROG, 6'h01);
		fail_p = 1'b0;
		run(OP_STATUS, 6'h01);
		rd(REG_STATUS, v);
		chk(v & 32'hFF00, 32'h9000);
		run(OP_CLEAR, 6'h01);
		wr(REG_CTRL, 32'h0C);
		$display("test program done");
		mask_v = 6'h3F;
		wr(REG_IRQ_MASK, {26'h0, mask_v});
		aw(18'h10010, 16'h00AA);
		run(OP_PROG, 6'h01);
		fail_e = 1'b1;
		run(OP_ERASE, 6'h09);
		fail_e = 1'b0;
		run(OP_ERASE, 6'h09);
		run(OP_CLEAR, 6'h01);
		run(OP_READ, 6'h01);
		rd(REG_RDATA, v);
		chk(v, 32'hFFFF);
		bad_seq = 1'b1;
		run(OP_ERASE, 6'h11);
		bad_seq = 1'b0;
		run(OP_CLEAR, 6'h01);
		aw(18'h30000, 16'h0000);
		run(OP_ERASE, 6'h09);
		run(OP_CLEAR, 6'h01);
		wr(REG_CTRL, 32'h0E);
		run(OP_ERASE, 6'h01);
		wr(REG_CTRL, 32'h0C);
		$display("test erase done");
		vpp_low = 1'b1;
		aw(18'h00102, 16'h0001);
		run(OP_PROG, 6'h03);
		rd(REG_STATUS, v);
		chk(v & 32'h8, 32'h8);
		vpp_low = 1'b0;
		run(OP_PROG, 6'h20);
		run(OP_CLEAR, 6'h01);
		run(OP_PROG, 6'h01);
		$display("test supply done");
		wr(REG_CTRL, 32'h0D);
		rd(REG_STATUS, v);
		chk(v & 32'h1, 32'h1);
		chk({31'h0, rp_n}, 32'h0);
		wr(REG_CTRL, 32'h0C);
		run(OP_PROG, 6'h20);
		aw(18'h00200, 16'h5A5A);
		run(OP_PROG, 6'h01);
		wr(REG_CTRL, 32'h1C);
		aw(18'h20000, 16'h0000);
		run(OP_ERASE, 6'h01);
		run(OP_PROG, 6'h20);
		run(OP_SUSP, 6'h01);
		rd(REG_STATUS, v);
		chk(v & 32'h7, 32'h6);
		run(OP_PROG, 6'h20);
		run(OP_READ, 6'h20);
		aw(18'h00200, 16'h0000);
		run(OP_READ, 6'h01);
		rd(REG_RDATA, v);
		chk(v, 32'h5A5A);
		run(OP_RESUME, 6'h01);
		run(OP_WAIT, 6'h01);
		rd(REG_STATUS, v);
		chk(v & 32'h7, 32'h0);
		wr(REG_CTRL, 32'h0C);
		$display("test suspend done");
		wrap_up();
	end
endmodule // tb_top
